// ---- btpm_pkg.sv ----
package btpm_pkg;

   // ==========================================================
   // Sequencer states
   // ==========================================================
   typedef enum logic [2:0] {
      BTPM_ST_CLKWAIT  = 3'b000,
      BTPM_ST_AWAKE    = 3'b001,
      BTPM_ST_SLEEP    = 3'b010,
      BTPM_ST_LOWPWR   = 3'b011,
      BTPM_ST_SHUTDOWN = 3'b100
   } btpm_state_e;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int unsigned CLOCK_PERIOD_NS = 100;
   // Reference clock settling time used when software programs zero.
   localparam int unsigned REFCLK_SETTLE_NS = 2000;
   // A least time, so round up.
   localparam int unsigned REFCLK_SETTLE_CYC =
      (REFCLK_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

   // ==========================================================
   // Widths and reset values
   // ==========================================================
   localparam int unsigned SETTLE_W = 16;
   localparam int unsigned LP_W = 16;
   localparam logic [SETTLE_W-1:0] SETTLE_RST = '0;
   localparam logic [LP_W-1:0] LP_RST = '0;
   localparam logic [3:0] RADIO_PD_RST = 4'hf;
   localparam int unsigned RADIO_TX = 0;
   localparam int unsigned RADIO_RX = 1;
   localparam int unsigned RADIO_PLL = 2;
   localparam int unsigned RADIO_PA = 3;

endpackage

// ---- btpm_buf_if.sv ----
`timescale 1ns/1ps
interface btpm_buf_if #(
   parameter int unsigned WIDTH = 8
);
   logic wr_valid;
   logic wr_ready;
   logic [WIDTH-1:0] wr_data;
   logic rd_valid;
   logic rd_ready;
   logic [WIDTH-1:0] rd_data;
   logic flush;
   logic empty;

   modport owner (output wr_valid, input wr_ready, output wr_data,
                  input rd_valid, output rd_ready, input rd_data,
                  output flush, input empty);
   modport store (input wr_valid, output wr_ready, input wr_data,
                  output rd_valid, input rd_ready, output rd_data,
                  input flush, output empty);
endinterface

// ---- btpm_burst_buf.sv ----
`timescale 1ns/1ps
module btpm_burst_buf #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // Buffer port.
   btpm_buf_if.store bus
);

   localparam int unsigned AW = $clog2(DEPTH);

   // ==========================================================
   // Storage and pointers
   // ==========================================================
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic do_wr, do_rd;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign bus.wr_ready = (cnt_r != (AW+1)'(DEPTH));
   assign bus.rd_valid = (cnt_r != '0);
   assign bus.rd_data = mem_r[rp_r];
   assign bus.empty = (cnt_r == '0);
   assign do_wr = bus.wr_valid && bus.wr_ready;
   assign do_rd = bus.rd_valid && bus.rd_ready;

   // Flush wins over traffic so a power-up leaves nothing behind.
   always_comb begin
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      if (bus.flush) begin
         wp_nxt = '0;
         rp_nxt = '0;
         cnt_nxt = '0;
      end else begin
         if (do_wr) wp_nxt = bump(wp_r);
         if (do_rd) rp_nxt = bump(rp_r);
         cnt_nxt = cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Data words need no reset; they are only read while counted.
   always_ff @(posedge clock) begin
      if (do_wr && !bus.flush) begin
         mem_r[wp_r] <= bus.wr_data;
      end
   end

endmodule // btpm_burst_buf

// ---- btpm_sequencer.sv ----
`timescale 1ns/1ps
// What this block does
// - Wake handshake pins work only when enabled and host transport is UART.
// - Asserted wake request wakes the device and keeps it awake.
// - Released wake request allows sleep only when internal sleep criteria hold.
// - Polarity of wake request and host alert is software selectable.
// - Host alert asserts while attention is needed, deasserts otherwise.
// - Reference clock request is active high when Bluetooth or WLAN needs it.
// - Sleep can be triggered by software writes or by baseband packet handling.
// - Separate power-down outputs for transmit, receive, PLL and amplifier.
// - Radio paths are powered only during active packet portions.
// - Sniff, hold and park run on the slow oscillator and wake on timeout.
// - Shutdown tristates the host alert and clock request pins and ignores most inputs.
// - Leaving shutdown behaves as power-up with no state kept except the last burst word still on out_data.
// - Transport data is buffered and later sent at an increased rate.
module btpm_sequencer #(
   parameter int unsigned DATA_W = 8,
   parameter int unsigned BUF_DEPTH = 16
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // Configuration levels.
   input wire logic uart_mode,
   input wire logic handshake_enable,
   input wire logic wake_active_high,
   input wire logic alert_active_high,
   input wire logic [btpm_pkg::SETTLE_W-1:0] settle_cycles,
   // Host handshake pins.
   input wire logic wake_request_in,
   output logic host_alert_out,
   output logic host_alert_oe,
   output logic refclk_request_out,
   output logic refclk_request_oe,
   // Slow oscillator.
   input wire logic low_power_osc_input,
   // Power unit requests.
   input wire logic sw_sleep_request,
   input wire logic pkt_sleep_request,
   input wire logic core_sleep_ok,
   input wire logic attention_request,
   input wire logic wlan_clk_need,
   input wire logic lowpwr_enter,
   input wire logic [btpm_pkg::LP_W-1:0] lowpwr_ticks,
   input wire logic shutdown_request,
   input wire logic power_on_request,
   // Baseband packet activity.
   input wire logic tx_active,
   input wire logic rx_active,
   // Radio power-down controls, high means powered down.
   output logic tx_pd,
   output logic rx_pd,
   output logic pll_pd,
   output logic pa_pd,
   // Transport data in.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [DATA_W-1:0] in_data,
   // Burst data out.
   output logic out_valid,
   input wire logic out_ready,
   output logic [DATA_W-1:0] out_data,
   // Status.
   output logic awake,
   output logic refclk_valid
);

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   logic wake_s1_r, wake_s2_r, lpo_s1_r, lpo_s2_r, lpo_s3_r;

   // The first stage is read only by the second; metastability stays there.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wake_s1_r <= 1'b0;
         wake_s2_r <= 1'b0;
         lpo_s1_r <= 1'b0;
         lpo_s2_r <= 1'b0;
         lpo_s3_r <= 1'b0;
      end else begin
         wake_s1_r <= wake_request_in;
         wake_s2_r <= wake_s1_r;
         lpo_s1_r <= low_power_osc_input;
         lpo_s2_r <= lpo_s1_r;
         lpo_s3_r <= lpo_s2_r;
      end
   end

   // ==========================================================
   // Decoded conditions
   // ==========================================================
   logic hs_on, wake_asserted, lpo_tick, sleep_trigger, buf_empty;

   // The handshake is meaningless on other transports, so it is gated here.
   assign hs_on = handshake_enable && uart_mode;
   assign wake_asserted = hs_on && (wake_s2_r == wake_active_high);
   assign lpo_tick = lpo_s2_r && !lpo_s3_r;
   assign sleep_trigger = sw_sleep_request || pkt_sleep_request;

   // ==========================================================
   // Sequencer state
   // ==========================================================
   btpm_pkg::btpm_state_e st_r, st_nxt;
   logic [btpm_pkg::SETTLE_W-1:0] settle_r, settle_nxt, settle_len;
   logic [btpm_pkg::LP_W-1:0] lp_r, lp_nxt;
   logic clkreq_r, clkreq_nxt, clkreq_oe_r, clkreq_oe_nxt;

   // Zero programmed means use the built-in settling time.
   assign settle_len = (settle_cycles == '0) ?
      btpm_pkg::SETTLE_W'(btpm_pkg::REFCLK_SETTLE_CYC) : settle_cycles;

   // Shutdown has top priority in every live state; leaving it loads the
   // same values as the reset branch, so no history survives.
   always_comb begin
      st_nxt = st_r;
      settle_nxt = settle_r;
      lp_nxt = lp_r;
      unique case (st_r)
         btpm_pkg::BTPM_ST_CLKWAIT: begin
            if (shutdown_request) begin
               st_nxt = btpm_pkg::BTPM_ST_SHUTDOWN;
            end else if (!clkreq_r) begin
               // After reset the request is not yet on the pin, so settling has not begun.
               settle_nxt = btpm_pkg::SETTLE_RST;
            end else if (settle_r >= settle_len - 1'b1) begin
               st_nxt = btpm_pkg::BTPM_ST_AWAKE;
               settle_nxt = btpm_pkg::SETTLE_RST;
            end else begin
               settle_nxt = settle_r + 1'b1;
            end
         end
         btpm_pkg::BTPM_ST_AWAKE: begin
            if (shutdown_request) begin
               st_nxt = btpm_pkg::BTPM_ST_SHUTDOWN;
            end else if (wake_asserted) begin
               st_nxt = btpm_pkg::BTPM_ST_AWAKE;
            end else if (lowpwr_enter) begin
               st_nxt = btpm_pkg::BTPM_ST_LOWPWR;
               lp_nxt = lowpwr_ticks;
            end else if (sleep_trigger && core_sleep_ok && buf_empty) begin
               st_nxt = btpm_pkg::BTPM_ST_SLEEP;
            end
         end
         btpm_pkg::BTPM_ST_SLEEP: begin
            if (shutdown_request) begin
               st_nxt = btpm_pkg::BTPM_ST_SHUTDOWN;
            end else if (wake_asserted || attention_request || !buf_empty) begin
               st_nxt = btpm_pkg::BTPM_ST_CLKWAIT;
               settle_nxt = btpm_pkg::SETTLE_RST;
            end
         end
         btpm_pkg::BTPM_ST_LOWPWR: begin
            if (shutdown_request) begin
               st_nxt = btpm_pkg::BTPM_ST_SHUTDOWN;
            end else if (wake_asserted || lp_r == '0) begin
               st_nxt = btpm_pkg::BTPM_ST_CLKWAIT;
               settle_nxt = btpm_pkg::SETTLE_RST;
            end else if (lpo_tick) begin
               lp_nxt = lp_r - 1'b1;
            end
         end
         btpm_pkg::BTPM_ST_SHUTDOWN: begin
            settle_nxt = btpm_pkg::SETTLE_RST;
            lp_nxt = btpm_pkg::LP_RST;
            if (power_on_request) begin
               st_nxt = btpm_pkg::BTPM_ST_CLKWAIT;
            end
         end
         default: begin
            st_nxt = btpm_pkg::BTPM_ST_CLKWAIT;
            settle_nxt = btpm_pkg::SETTLE_RST;
            lp_nxt = btpm_pkg::LP_RST;
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= btpm_pkg::BTPM_ST_CLKWAIT;
         settle_r <= btpm_pkg::SETTLE_RST;
         lp_r <= btpm_pkg::LP_RST;
      end else begin
         st_r <= st_nxt;
         settle_r <= settle_nxt;
         lp_r <= lp_nxt;
      end
   end

   // ==========================================================
   // Pin and radio outputs
   // ==========================================================
   logic alert_r, alert_nxt, alert_oe_r, alert_oe_nxt;
   logic [3:0] pd_r, pd_nxt;
   logic awake_r, awake_nxt, clkvalid_r, clkvalid_nxt;
   logic need_host, live;

   assign live = (st_nxt != btpm_pkg::BTPM_ST_SHUTDOWN);
   // Pending burst data is a reason to keep the host up.
   assign need_host = attention_request || !buf_empty;

   // Computed from the next state so pins follow the state in the same edge.
   always_comb begin
      awake_nxt = (st_nxt == btpm_pkg::BTPM_ST_AWAKE);
      clkvalid_nxt = awake_nxt;
      alert_oe_nxt = live;
      clkreq_oe_nxt = live;
      // Deasserted level is driven whenever the handshake is off.
      alert_nxt = (hs_on && need_host) ? alert_active_high : !alert_active_high;
      clkreq_nxt = live && (st_nxt == btpm_pkg::BTPM_ST_CLKWAIT || awake_nxt ||
                            wlan_clk_need);
      pd_nxt = btpm_pkg::RADIO_PD_RST;
      if (awake_nxt) begin
         pd_nxt[btpm_pkg::RADIO_TX] = !tx_active;
         pd_nxt[btpm_pkg::RADIO_RX] = !rx_active;
         pd_nxt[btpm_pkg::RADIO_PLL] = !(tx_active || rx_active);
         pd_nxt[btpm_pkg::RADIO_PA] = !tx_active;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         alert_r <= 1'b0;
         alert_oe_r <= 1'b0;
         clkreq_r <= 1'b0;
         clkreq_oe_r <= 1'b0;
         pd_r <= btpm_pkg::RADIO_PD_RST;
         awake_r <= 1'b0;
         clkvalid_r <= 1'b0;
      end else begin
         alert_r <= alert_nxt;
         alert_oe_r <= alert_oe_nxt;
         clkreq_r <= clkreq_nxt;
         clkreq_oe_r <= clkreq_oe_nxt;
         pd_r <= pd_nxt;
         awake_r <= awake_nxt;
         clkvalid_r <= clkvalid_nxt;
      end
   end

   assign host_alert_out = alert_r;
   assign host_alert_oe = alert_oe_r;
   assign refclk_request_out = clkreq_r;
   assign refclk_request_oe = clkreq_oe_r;
   assign tx_pd = pd_r[btpm_pkg::RADIO_TX];
   assign rx_pd = pd_r[btpm_pkg::RADIO_RX];
   assign pll_pd = pd_r[btpm_pkg::RADIO_PLL];
   assign pa_pd = pd_r[btpm_pkg::RADIO_PA];
   assign awake = awake_r;
   assign refclk_valid = clkvalid_r;

   // ==========================================================
   // Burst buffer
   // ==========================================================
   btpm_buf_if #(.WIDTH(DATA_W)) buf_bus ();

   btpm_burst_buf #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH)) u_buf (
      .clock(clock),
      .reset_n(reset_n),
      .bus(buf_bus)
   );

   logic ovalid_r, ovalid_nxt, load;
   logic [DATA_W-1:0] odata_r, odata_nxt;

   assign buf_empty = buf_bus.empty;
   // Inputs are refused while the pins are released: in shutdown and just after reset.
   assign buf_bus.wr_valid = in_valid && clkreq_oe_r;
   assign buf_bus.wr_data = in_data;
   assign in_ready = buf_bus.wr_ready && clkreq_oe_r;
   assign buf_bus.flush = (st_r == btpm_pkg::BTPM_ST_SHUTDOWN);
   // Draining only while awake, one word per clock, gives the burst rate.
   assign load = awake_r && (!ovalid_r || out_ready);
   assign buf_bus.rd_ready = load;

   // Output stage keeps the data on a flip-flop and holds it under stall.
   always_comb begin
      ovalid_nxt = ovalid_r;
      odata_nxt = odata_r;
      if (!live) begin
         ovalid_nxt = 1'b0;
      end else if (load) begin
         ovalid_nxt = buf_bus.rd_valid;
         odata_nxt = buf_bus.rd_valid ? buf_bus.rd_data : odata_r;
      end else if (out_ready) begin
         ovalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ovalid_r <= 1'b0;
         odata_r <= '0;
      end else begin
         ovalid_r <= ovalid_nxt;
         odata_r <= odata_nxt;
      end
   end

   assign out_valid = ovalid_r;
   assign out_data = odata_r;

endmodule // btpm_sequencer

// ---- btpm_chk.sv ----
`timescale 1ns/1ps
// ==========
// Pin checker for the sequencer.
module btpm_chk #(
   parameter int unsigned DATA_W = 8
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // Configuration and requests.
   input wire logic uart_mode,
   input wire logic handshake_enable,
   input wire logic wake_active_high,
   input wire logic alert_active_high,
   input wire logic wake_request_in,
   input wire logic sw_sleep_request,
   input wire logic pkt_sleep_request,
   input wire logic core_sleep_ok,
   input wire logic attention_request,
   input wire logic wlan_clk_need,
   input wire logic lowpwr_enter,
   input wire logic shutdown_request,
   input wire logic tx_active,
   input wire logic rx_active,
   input wire logic out_ready,
   // Outputs.
   input wire logic host_alert_out,
   input wire logic host_alert_oe,
   input wire logic refclk_request_out,
   input wire logic refclk_request_oe,
   input wire logic tx_pd,
   input wire logic rx_pd,
   input wire logic pll_pd,
   input wire logic pa_pd,
   input wire logic in_ready,
   input wire logic out_valid,
   input wire logic [DATA_W-1:0] out_data,
   input wire logic awake
);
   // Handshake is live only with the transport in UART mode.
   wire hs_on = handshake_enable && uart_mode;
   wire wake_on = hs_on && (wake_request_in == wake_active_high);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   AST_PD_IDLE: assert property (!awake |-> tx_pd && rx_pd && pll_pd && pa_pd)
      else $error("radio powered while not awake");
   AST_PD_PKT: assert property (awake |-> tx_pd == !$past(tx_active) && pa_pd == !$past(tx_active)
      && rx_pd == !$past(rx_active) && pll_pd == !($past(tx_active) || $past(rx_active)))
      else $error("radio power does not follow packet activity");
   AST_CLK_SETTLE: assert property ($rose(awake) |-> $past(refclk_request_out)
      && $past(refclk_request_out, 2)) else $error("awake before clock settled");
   AST_CLK_REQ: assert property (host_alert_oe && (awake || $past(wlan_clk_need))
      |-> refclk_request_out) else $error("clock request missing");
   AST_SHUT_TRI: assert property ($past(reset_n) && $past(shutdown_request)
      |-> !host_alert_oe && !refclk_request_oe) else $error("pins driven in shutdown");
   AST_SHUT_QUIET: assert property (!refclk_request_oe
      |-> !host_alert_oe && !awake && !in_ready && !out_valid) else $error("shutdown not quiet");
   AST_WAKE_HOLD: assert property (wake_on [*3] ##0 (awake && !shutdown_request) |=> awake)
      else $error("slept with wake held");
   AST_SLEEP_GATE: assert property ($fell(awake) && refclk_request_oe && !$past(lowpwr_enter)
      |-> $past(core_sleep_ok) && ($past(sw_sleep_request) || $past(pkt_sleep_request)))
      else $error("slept without criteria");
   AST_ALERT_ON: assert property ($past(reset_n) && host_alert_oe
      && $past(hs_on && attention_request) |-> host_alert_out == $past(alert_active_high))
      else $error("alert not asserted");
   AST_ALERT_OFF: assert property (host_alert_oe && !$past(hs_on)
      |-> host_alert_out == !$past(alert_active_high)) else $error("alert with handshake off");
   AST_OUT_HOLD: assert property (out_valid && !out_ready && !shutdown_request
      |=> out_valid && $stable(out_data)) else $error("burst word dropped");
endmodule // btpm_chk

bind btpm_sequencer btpm_chk #(.DATA_W(DATA_W)) i_chk (.clock, .reset_n, .uart_mode,
   .handshake_enable, .wake_active_high, .alert_active_high, .wake_request_in,
   .sw_sleep_request, .pkt_sleep_request, .core_sleep_ok, .attention_request, .wlan_clk_need,
   .lowpwr_enter, .shutdown_request, .tx_active, .rx_active, .out_ready, .host_alert_out,
   .host_alert_oe, .refclk_request_out, .refclk_request_oe, .tx_pd, .rx_pd, .pll_pd, .pa_pd,
   .in_ready, .out_valid, .out_data, .awake);

// ---- btpm_host_model.sv ----
`timescale 1ns/1ps
// ==========
// Host side of the wake handshake.
module btpm_host_model (
   // Bench controls.
   input wire logic want_wake,
   input wire logic wake_active_high,
   input wire logic alert_active_high,
   // Device pins.
   input wire logic host_alert_out,
   input wire logic host_alert_oe,
   output logic wake_request_in,
   // Host state.
   output logic host_awake
);
   // The alert line has a pull-up, so a released line reads high.
   wire alert_wire = host_alert_oe ? host_alert_out : 1'b1;
   // The wake line is always driven, at the level the polarity asks for.
   assign wake_request_in = want_wake ? wake_active_high : !wake_active_high;
   // The host stays up while alerted or while it has work of its own.
   assign host_awake = (alert_wire == alert_active_high) || want_wake;
endmodule // btpm_host_model

// ---- testbench.sv ----
`timescale 1ns/1ps
// ==========
// Bench top.
module testbench;
   logic clock = 1'b0, reset_n = 1'b0, uart_mode = 1'b1, handshake_enable = 1'b1;
   logic wake_active_high = 1'b1, alert_active_high = 1'b1, want_wake = 1'b0;
   logic sw_sleep_request = 1'b0, pkt_sleep_request = 1'b0, core_sleep_ok = 1'b1;
   logic attention_request = 1'b0, wlan_clk_need = 1'b0, lowpwr_enter = 1'b0;
   logic shutdown_request = 1'b0, power_on_request = 1'b0, tx_active = 1'b0;
   logic rx_active = 1'b0, in_valid = 1'b0, out_ready = 1'b0, low_power_osc_input = 1'b0;
   logic [7:0] in_data = 8'h00, out_data;
   logic [15:0] lowpwr_ticks = 16'h0003;
   logic [2:0] lpo_div = 3'h0;
   logic host_awake, wake_request_in, host_alert_out, host_alert_oe, refclk_request_out;
   logic refclk_request_oe, tx_pd, rx_pd, pll_pd, pa_pd, in_ready, out_valid, awake;
   logic refclk_valid;
   int fail_count = 0, samples_checked = 0, cycles = 0;

   btpm_sequencer i_dut (.clock, .reset_n, .uart_mode, .handshake_enable, .wake_active_high,
      .alert_active_high, .settle_cycles(16'h0002), .wake_request_in, .host_alert_out,
      .host_alert_oe, .refclk_request_out, .refclk_request_oe, .low_power_osc_input,
      .sw_sleep_request, .pkt_sleep_request, .core_sleep_ok, .attention_request,
      .wlan_clk_need, .lowpwr_enter, .lowpwr_ticks, .shutdown_request, .power_on_request,
      .tx_active, .rx_active, .tx_pd, .rx_pd, .pll_pd, .pa_pd, .in_valid, .in_ready, .in_data,
      .out_valid, .out_ready, .out_data, .awake, .refclk_valid);
   btpm_host_model i_host (.want_wake, .wake_active_high, .alert_active_high, .host_alert_out,
      .host_alert_oe, .wake_request_in, .host_awake);

   // Clock generator.
   initial begin
      forever #50 clock = ~clock;
   end
   // Slow oscillator at an eighth of the clock, so sleep times stay short; also the timeout.
   always @(posedge clock) begin
      lpo_div <= lpo_div + 3'h1;
      low_power_osc_input <= lpo_div[2];
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count = fail_count + 1;
         finish_test();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic see(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask
   // A bounded wait keeps a stuck sequencer from hanging the run.
   task automatic wait_awake(input logic v, input int lim);
      int k;
      k = 0;
      while (awake !== v && k < lim) begin
         @(negedge clock);
         k = k + 1;
      end
      chk(awake, v);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic t_start;
      see(1);
      chk({refclk_request_out, awake, refclk_valid}, 3'h4);
      wait_awake(1'b1, 40);
      chk(refclk_valid, 1'b1);
      $display("start done");
   endtask
   task automatic t_radio;
      for (int i = 0; i < 5; i++) begin
         @(posedge clock);
         tx_active <= i[0];
         rx_active <= i[1];
         see(1);
         chk({tx_pd, rx_pd, pll_pd, pa_pd}, {!i[0], !i[1], !(i[0] | i[1]), !i[0]});
      end
      $display("radio done");
   endtask
   task automatic t_sleep;
      @(posedge clock);
      core_sleep_ok <= 1'b0;
      sw_sleep_request <= 1'b1;
      see(3);
      chk(awake, 1'b1);
      @(posedge clock);
      core_sleep_ok <= 1'b1;
      see(1);
      chk({awake, refclk_request_out, tx_pd, pll_pd}, 4'h3);
      @(posedge clock);
      sw_sleep_request <= 1'b0;
      wlan_clk_need <= 1'b1;
      see(1);
      chk({awake, refclk_request_out}, 2'h1);
      @(posedge clock);
      wlan_clk_need <= 1'b0;
      want_wake <= 1'b1;
      see(2);
      chk({awake, refclk_request_out}, 2'h0);
      wait_awake(1'b1, 20);
      @(posedge clock);
      pkt_sleep_request <= 1'b1;
      see(3);
      chk(awake, 1'b1);
      @(posedge clock);
      want_wake <= 1'b0;
      wait_awake(1'b0, 10);
      chk(host_awake, 1'b0);
      @(posedge clock);
      pkt_sleep_request <= 1'b0;
      attention_request <= 1'b1;
      see(1);
      chk({host_alert_out, host_awake}, 2'h3);
      wait_awake(1'b1, 20);
      @(posedge clock);
      attention_request <= 1'b0;
      see(1);
      chk(host_alert_out, 1'b0);
      $display("sleep done");
   endtask
   task automatic t_polarity;
      @(posedge clock);
      alert_active_high <= 1'b0;
      wake_active_high <= 1'b0;
      attention_request <= 1'b1;
      see(1);
      chk(host_alert_out, 1'b0);
      @(posedge clock);
      attention_request <= 1'b0;
      uart_mode <= 1'b0;
      want_wake <= 1'b1;
      sw_sleep_request <= 1'b1;
      see(4);
      chk({awake, host_alert_out}, 2'h1);
      @(posedge clock);
      uart_mode <= 1'b1;
      sw_sleep_request <= 1'b0;
      wait_awake(1'b1, 20);
      @(posedge clock);
      want_wake <= 1'b0;
      alert_active_high <= 1'b1;
      wake_active_high <= 1'b1;
      $display("polarity done");
   endtask
   task automatic t_lowpwr;
      @(posedge clock);
      lowpwr_enter <= 1'b1;
      see(1);
      chk({awake, refclk_request_out}, 2'h0);
      @(posedge clock);
      lowpwr_enter <= 1'b0;
      see(8);
      chk(awake, 1'b0);
      wait_awake(1'b1, 60);
      $display("lowpwr done");
   endtask
   task automatic t_burst;
      chk(in_ready, 1'b1);
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         in_valid <= (i < 3);
         in_data <= 8'ha1 + 8'(i);
      end
      see(2);
      chk({out_valid, out_data, host_alert_out}, {1'b1, 8'ha1, 1'b1});
      @(posedge clock);
      out_ready <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         @(negedge clock);
         chk({out_valid, out_data}, {1'b1, 8'ha1 + 8'(i)});
         @(posedge clock);
      end
      out_ready <= 1'b0;
      see(0);
      chk(out_valid, 1'b0);
      $display("burst done");
   endtask
   task automatic t_shut;
      @(posedge clock);
      in_valid <= 1'b1;
      in_data <= 8'h5c;
      @(posedge clock);
      in_valid <= 1'b0;
      shutdown_request <= 1'b1;
      attention_request <= 1'b1;
      see(1);
      chk({host_alert_oe, refclk_request_oe, awake, in_ready, out_valid}, 5'h00);
      @(posedge clock);
      shutdown_request <= 1'b0;
      attention_request <= 1'b0;
      power_on_request <= 1'b1;
      see(1);
      chk({refclk_request_oe, refclk_request_out, awake, out_valid}, 4'hc);
      @(posedge clock);
      power_on_request <= 1'b0;
      wait_awake(1'b1, 20);
      chk(out_valid, 1'b0);
      $display("shutdown done");
   endtask

   // Main sequence: reset for three cycles, then the scenarios in turn.
   initial begin
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      t_start();
      t_radio();
      t_sleep();
      t_polarity();
      t_lowpwr();
      t_burst();
      t_shut();
      finish_test();
   end
endmodule // testbench
